// ==== rtl/ppfm_defs.svh ====
`ifndef PPFM_DEFS_SVH
`define PPFM_DEFS_SVH
// ==========================================================
// register offsets (word indices decoded from wb_adr_i[5:2], one word each)
`define PPFM_ADR_P1_LATCH 4'h0
`define PPFM_ADR_P2_LATCH 4'h1
`define PPFM_ADR_P3_LATCH 4'h2
`define PPFM_ADR_P1_ANA 4'h3
`define PPFM_ADR_P3_ANA 4'h4
`define PPFM_ADR_TRAP_EN 4'h5
`define PPFM_ADR_TRAP_LVL 4'h6
`define PPFM_ADR_CTRL 4'h7
`define PPFM_ADR_P1_PIN 4'h8
`define PPFM_ADR_P2_PIN 4'h9
`define PPFM_ADR_P3_PIN 4'hA
`define PPFM_ADR_STATUS 4'hB
// ==========================================================
// reset values
`define PPFM_RST_LATCH 8'hFF
`define PPFM_RST_ANA 4'h0
`define PPFM_RST_TRAP 3'h0
`define PPFM_RST_CTRL 2'h0
// ==========================================================
// control register fields
`define PPFM_CTRL_SYNC 0
`define PPFM_CTRL_EXT_IRQ2_PIN 1
// ==========================================================
// pin positions on port 3
`define PPFM_P3_RXD 0
`define PPFM_P3_TXD 1
`define PPFM_P3_WR 6
`define PPFM_P3_RD 7
`endif

// ==== rtl/ppfm_pkg.sv ====
package ppfm_pkg;
    // external bus phase seen by the pin mux
    typedef enum logic [1:0] {
        PPFM_BUS_IDLE,
        PPFM_BUS_FETCH,
        PPFM_BUS_DATA16,
        PPFM_BUS_DATA8
    } ppfm_bus_t;
endpackage

// ==== rtl/ppfm_sync.sv ====
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser for a pin vector
module ppfm_sync #(
    parameter int W = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [W-1:0] d_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ppfm_sync_state_t;
    ppfm_sync_state_t state_reg; // both stages
    ppfm_sync_state_t state_next;

    // shift pins through the stages
    always_comb begin
        state_next.s1 = d_i;
        state_next.s2 = state_reg.s1;
    end

    // stages reset high (pins idle high)
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q_o = state_reg.s2;
endmodule

// ==== rtl/ppfm_top.sv ====
`timescale 1ns/1ps
`include "ppfm_defs.svh"
// Function
// RULE1 - port1 pins 0-3 selectable as analog 0-3
// RULE2 - port3 pins 2-5 selectable as analog 4-7
// RULE3 - port1 timer2 and capture/compare pin map
// RULE4 - port3 serial receive/transmit or sync data/clock
// RULE5 - port3 pins feed interrupts, gates, counters
// RULE6 - port3 pins 6/7 drive write/read strobes
// RULE7 - port3 pin 6 may be interrupt 2
// RULE8 - trap low forces enabled compares to level
// RULE9 - port2 latch one pulls pin high
// RULE10 - port2 drives upper address on wide accesses
// RULE11 - port2 drives latch on 8-bit data accesses
// RULE12 - port0 carries muxed low address/data
// RULE13 - alternate output ANDed with latch bit
module ppfm_top (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core side: external bus
    input wire ppfm_pkg::ppfm_bus_t bus_phase_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [7:0] bus_rdata_o,
    // core side: peripheral functions
    input wire logic [2:0] compare_out_i,
    input wire logic [2:0] capcom_out_i,
    input wire logic txd_i,
    input wire logic sync_data_out_i,
    output logic timer2_count_input_o,
    output logic timer2_trigger_input_o,
    output logic [2:0] capcom_in_o,
    output logic rxd_o,
    output logic ext_irq0_o,
    output logic ext_irq1_pin_o,
    output logic ext_irq2_pin_o,
    output logic timer0_gate_o,
    output logic timer1_gate_o,
    output logic timer0_count_input_o,
    output logic timer1_count_input_o,
    output logic [7:0] analog_sel_o,
    // pins
    input wire logic ccu_fault_input_i,
    input wire logic [7:0] p0_i,
    output logic [7:0] p0_o,
    output logic [7:0] p0_oe_o,
    input wire logic [7:0] p1_i,
    output logic [7:0] p1_o,
    output logic [7:0] p1_oe_o,
    input wire logic [7:0] p2_i,
    output logic [7:0] p2_o,
    output logic [7:0] p2_oe_o,
    input wire logic [7:0] p3_i,
    output logic [7:0] p3_o,
    output logic [7:0] p3_oe_o
);
    import ppfm_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] p1_latch;
        logic [7:0] port2_latch;
        logic [7:0] p3_latch;
        logic [3:0] port1_analog_sel;
        logic [3:0] port3_analog_sel;
        logic [2:0] trap_enable_reg;
        logic [2:0] compare_trap_level_reg;
        logic [1:0] ctrl;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] p0_out;
        logic [7:0] p0_oe;
        logic [7:0] p1_out;
        logic [7:0] p1_oe;
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
        logic [7:0] p3_out;
        logic [7:0] p3_oe;
        logic [7:0] bus_rdata;
        logic [19:0] func_in;
        logic [7:0] ana;
    } ppfm_state_t;
    ppfm_state_t state_reg; // all flops
    ppfm_state_t state_next; // their next value

    logic [7:0] p0_s; // synchronised pins
    logic [7:0] p1_s;
    logic [7:0] p2_s;
    logic [7:0] p3_s;
    logic fault_s;

    // ==========================================================
    // pin synchronisers
    ppfm_sync #(.W(8)) u_sync_p0 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .d_i(p0_i),
        .rst_val_i(8'hFF), .q_o(p0_s));
    ppfm_sync #(.W(8)) u_sync_p1 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .d_i(p1_i),
        .rst_val_i(8'hFF), .q_o(p1_s));
    ppfm_sync #(.W(8)) u_sync_p2 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .d_i(p2_i),
        .rst_val_i(8'hFF), .q_o(p2_s));
    ppfm_sync #(.W(8)) u_sync_p3 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .d_i(p3_i),
        .rst_val_i(8'hFF), .q_o(p3_s));
    ppfm_sync #(.W(1)) u_sync_f (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .d_i(ccu_fault_input_i), .rst_val_i(1'b1), .q_o(fault_s));

    // ==========================================================
    // byte-lane merge of a write
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        merge8 = sel[0] ? d[7:0] : old;
    endfunction

    // latch-gated alternate output: pin shows 0 only if latch or function is 0
    function automatic logic alt_out(input logic latch, input logic f);
        alt_out = latch & f;
    endfunction

    // ==========================================================
    // next-state logic
    always_comb begin
        logic wr;
        logic [2:0] cmp;
        logic [7:0] p1v;
        logic [7:0] p3v;
        wr = 1'b0;
        cmp = 3'h0;
        p1v = 8'h00;
        p3v = 8'h00;
        state_next = state_reg;

        // wishbone: one-cycle ack; a write lands at the edge the master sees ack
        state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        wr = state_reg.ack & wb_cyc_i & wb_stb_i & wb_we_i;
        if (wr) begin
            case (wb_adr_i[5:2])
                `PPFM_ADR_P1_LATCH: state_next.p1_latch = merge8(state_reg.p1_latch,
                    wb_dat_i, wb_sel_i);
                `PPFM_ADR_P2_LATCH: state_next.port2_latch = merge8(state_reg.port2_latch,
                    wb_dat_i, wb_sel_i);
                `PPFM_ADR_P3_LATCH: state_next.p3_latch = merge8(state_reg.p3_latch,
                    wb_dat_i, wb_sel_i);
                `PPFM_ADR_P1_ANA: if (wb_sel_i[0]) begin
                    state_next.port1_analog_sel = wb_dat_i[3:0]; // [RULE1]
                end
                `PPFM_ADR_P3_ANA: if (wb_sel_i[0]) begin
                    state_next.port3_analog_sel = wb_dat_i[3:0]; // [RULE2]
                end
                `PPFM_ADR_TRAP_EN: if (wb_sel_i[0]) begin
                    state_next.trap_enable_reg = wb_dat_i[2:0];
                end
                `PPFM_ADR_TRAP_LVL: if (wb_sel_i[0]) begin
                    state_next.compare_trap_level_reg = wb_dat_i[2:0];
                end
                `PPFM_ADR_CTRL: if (wb_sel_i[0]) begin
                    state_next.ctrl = wb_dat_i[1:0];
                end
                default: begin
                end
            endcase
        end
        // read mux; unmapped reads as zero
        case (wb_adr_i[5:2])
            `PPFM_ADR_P1_LATCH: state_next.rdat = {24'h000000, state_reg.p1_latch};
            `PPFM_ADR_P2_LATCH: state_next.rdat = {24'h000000, state_reg.port2_latch};
            `PPFM_ADR_P3_LATCH: state_next.rdat = {24'h000000, state_reg.p3_latch};
            `PPFM_ADR_P1_ANA: state_next.rdat = {28'h0000000, state_reg.port1_analog_sel};
            `PPFM_ADR_P3_ANA: state_next.rdat = {28'h0000000, state_reg.port3_analog_sel};
            `PPFM_ADR_TRAP_EN: state_next.rdat = {29'h00000000, state_reg.trap_enable_reg};
            `PPFM_ADR_TRAP_LVL: state_next.rdat = {29'h0, state_reg.compare_trap_level_reg};
            `PPFM_ADR_CTRL: state_next.rdat = {30'h00000000, state_reg.ctrl};
            `PPFM_ADR_P1_PIN: state_next.rdat = {24'h000000, p1_s};
            `PPFM_ADR_P2_PIN: state_next.rdat = {24'h000000, p2_s};
            `PPFM_ADR_P3_PIN: state_next.rdat = {24'h000000, p3_s};
            `PPFM_ADR_STATUS: state_next.rdat = {31'h00000000, fault_s};
            default: state_next.rdat = 32'h00000000;
        endcase

        // analog selection, channels 0-3 on port1, 4-7 on port3
        state_next.ana = {state_reg.port3_analog_sel, state_reg.port1_analog_sel}; // [RULE1]

        // compare outputs, each overridden while the trap input is low and its trap_enable_reg bit is set
        for (int i = 0; i < 3; i++) begin
            cmp[i] = (!fault_s && state_reg.trap_enable_reg[i]) ?
                state_reg.compare_trap_level_reg[i] : compare_out_i[i]; // [RULE8]
        end

        // port1 pin values: capcom on 2/4/6, compare on 3/5/7
        p1v = state_reg.p1_latch;
        for (int i = 0; i < 3; i++) begin
            p1v[2 + 2 * i] = alt_out(state_reg.p1_latch[2 + 2 * i], capcom_out_i[i]); // [RULE3]
            p1v[3 + 2 * i] = alt_out(state_reg.p1_latch[3 + 2 * i], cmp[i]); // [RULE13]
        end
        // quasi-bidirectional: only a zero is driven; analog pins never driven
        state_next.p1_out = p1v;
        state_next.p1_oe = ~p1v & ~{4'h0, state_reg.port1_analog_sel}; // [RULE1]

        // port3: serial, strobes, latch elsewhere
        p3v = state_reg.p3_latch;
        p3v[`PPFM_P3_RXD] = state_reg.ctrl[`PPFM_CTRL_SYNC] ?
            alt_out(state_reg.p3_latch[`PPFM_P3_RXD], sync_data_out_i) :
            state_reg.p3_latch[`PPFM_P3_RXD]; // [RULE4]
        p3v[`PPFM_P3_TXD] = alt_out(state_reg.p3_latch[`PPFM_P3_TXD], txd_i); // [RULE4]
        p3v[`PPFM_P3_WR] = alt_out(state_reg.p3_latch[`PPFM_P3_WR], ~bus_wr_i); // [RULE6]
        p3v[`PPFM_P3_RD] = alt_out(state_reg.p3_latch[`PPFM_P3_RD], ~bus_rd_i); // [RULE6]
        state_next.p3_out = p3v;
        state_next.p3_oe = ~p3v & ~{2'b00, state_reg.port3_analog_sel, 2'b00}; // [RULE2]
        // strobes drive actively while a cycle is under way
        if (bus_wr_i | bus_rd_i) begin
            state_next.p3_oe[`PPFM_P3_WR] = 1'b1; // [RULE6]
            state_next.p3_oe[`PPFM_P3_RD] = 1'b1;
        end

        // port2: address high byte on wide accesses, latch otherwise
        case (bus_phase_i)
            PPFM_BUS_FETCH, PPFM_BUS_DATA16: begin
                state_next.p2_out = bus_addr_i[15:8]; // [RULE10]
                state_next.p2_oe = 8'hFF;
            end
            default: begin
                state_next.p2_out = state_reg.port2_latch; // [RULE11]
                state_next.p2_oe = ~state_reg.port2_latch; // [RULE9]
            end
        endcase

        // port0: low address or write data during external accesses
        case (bus_phase_i)
            PPFM_BUS_IDLE: begin
                state_next.p0_out = 8'h00;
                state_next.p0_oe = 8'h00;
            end
            default: begin
                state_next.p0_out = bus_wr_i ? bus_wdata_i : bus_addr_i[7:0]; // [RULE12]
                state_next.p0_oe = bus_rd_i ? 8'h00 : 8'hFF;
            end
        endcase
        state_next.bus_rdata = p0_s; // [RULE12]

        // digital inputs to functions, analog pins read as high
        state_next.func_in[0] = p1_s[0] | state_reg.port1_analog_sel[0]; // [RULE3]
        state_next.func_in[1] = p1_s[1] | state_reg.port1_analog_sel[1];
        state_next.func_in[2] = p1_s[2] | state_reg.port1_analog_sel[2];
        state_next.func_in[3] = p1_s[4];
        state_next.func_in[4] = p1_s[6];
        state_next.func_in[5] = p3_s[`PPFM_P3_RXD]; // [RULE4]
        state_next.func_in[6] = p3_s[2] | state_reg.port3_analog_sel[0]; // [RULE5]
        state_next.func_in[7] = p3_s[3] | state_reg.port3_analog_sel[1];
        state_next.func_in[8] = p3_s[4] | state_reg.port3_analog_sel[2];
        state_next.func_in[9] = p3_s[5] | state_reg.port3_analog_sel[3];
        state_next.func_in[10] = state_reg.ctrl[`PPFM_CTRL_EXT_IRQ2_PIN] ?
            p3_s[`PPFM_P3_WR] : 1'b1; // [RULE7]
        state_next.func_in[19:11] = 9'h000;
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
            state_reg.p1_latch <= `PPFM_RST_LATCH;
            state_reg.port2_latch <= `PPFM_RST_LATCH;
            state_reg.p3_latch <= `PPFM_RST_LATCH;
            state_reg.p1_out <= `PPFM_RST_LATCH;
            state_reg.p2_out <= `PPFM_RST_LATCH;
            state_reg.p3_out <= `PPFM_RST_LATCH;
            state_reg.func_in <= 20'hFFFFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdat;
    assign bus_rdata_o = state_reg.bus_rdata;
    assign p0_o = state_reg.p0_out;
    assign p0_oe_o = state_reg.p0_oe;
    assign p1_o = state_reg.p1_out;
    assign p1_oe_o = state_reg.p1_oe;
    assign p2_o = state_reg.p2_out;
    assign p2_oe_o = state_reg.p2_oe;
    assign p3_o = state_reg.p3_out;
    assign p3_oe_o = state_reg.p3_oe;
    assign analog_sel_o = state_reg.ana;
    assign timer2_count_input_o = state_reg.func_in[0];
    assign timer2_trigger_input_o = state_reg.func_in[1];
    assign capcom_in_o = {state_reg.func_in[4], state_reg.func_in[3], state_reg.func_in[2]};
    assign rxd_o = state_reg.func_in[5];
    assign ext_irq0_o = state_reg.func_in[6];
    assign timer0_gate_o = state_reg.func_in[6];
    assign ext_irq1_pin_o = state_reg.func_in[7];
    assign timer1_gate_o = state_reg.func_in[7];
    assign timer0_count_input_o = state_reg.func_in[8];
    assign timer1_count_input_o = state_reg.func_in[9];
    assign ext_irq2_pin_o = state_reg.func_in[10];

    // ==========================================================
    // checks
    property p_trap;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (!fault_s && state_reg.trap_enable_reg[0] && state_reg.p1_latch[3])
            |=> (p1_o[3] == $past(state_reg.compare_trap_level_reg[0]));
    endproperty
    a_trap: assert property (p_trap) else $error("trap level not forced"); // [RULE8]

    property p_addr_hi;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_phase_i == PPFM_BUS_DATA16) |=> (p2_o == $past(bus_addr_i[15:8])) && (&p2_oe_o);
    endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("port2 lacks address"); // [RULE10]

    property p_p2_latch;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_phase_i == PPFM_BUS_DATA8) |=> (p2_o == $past(state_reg.port2_latch));
    endproperty
    a_p2_latch: assert property (p_p2_latch) else $error("port2 lacks latch"); // [RULE11]

    property p_p2_pull;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_phase_i == PPFM_BUS_IDLE && state_reg.port2_latch[0]) |=> !p2_oe_o[0];
    endproperty
    a_p2_pull: assert property (p_p2_pull) else $error("port2 one driven"); // [RULE9]

    property p_ana1;
        @(posedge mclk_i) disable iff (!reset_n_i)
        state_reg.port1_analog_sel[0] |=> !p1_oe_o[0] && timer2_count_input_o;
    endproperty
    a_ana1: assert property (p_ana1) else $error("analog pin driven"); // [RULE1]

    property p_ana3;
        @(posedge mclk_i) disable iff (!reset_n_i)
        state_reg.port3_analog_sel[2] |=> !p3_oe_o[4] && timer0_count_input_o;
    endproperty
    a_ana3: assert property (p_ana3) else $error("port3 analog pin driven"); // [RULE2]

    property p_wr;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_wr_i && state_reg.p3_latch[6]) |=> !p3_o[6] && p3_oe_o[6];
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe missing"); // [RULE6]

    property p_latch0;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !state_reg.p3_latch[1] |=> !p3_o[1];
    endproperty
    a_latch0: assert property (p_latch0) else $error("latch zero not kept"); // [RULE13]

    property p_wb;
        @(posedge mclk_i) disable iff (!reset_n_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_wb: assert property (p_wb) else $error("ack held");

    property p_p0_addr;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_phase_i == PPFM_BUS_FETCH && !bus_wr_i) |=> (p0_o == $past(bus_addr_i[7:0]));
    endproperty
    a_p0_addr: assert property (p_p0_addr) else $error("port0 lacks low address"); // [RULE12]
endmodule

// ==== verif/ppfm_ext_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// far side: pull-ups, pin sources and external data memory
module ppfm_ext_model #(
    parameter logic [7:0] RD_BYTE = 8'hC3 // byte the memory returns
) (
    input wire logic mclk_i,
    input wire logic [7:0] p0_o_i,
    input wire logic [7:0] p0_oe_i,
    input wire logic [7:0] p1_o_i,
    input wire logic [7:0] p1_oe_i,
    input wire logic [7:0] p2_o_i,
    input wire logic [7:0] p2_oe_i,
    input wire logic [7:0] p3_o_i,
    input wire logic [7:0] p3_oe_i,
    input wire logic [7:0] p1_src_i,
    input wire logic [7:0] p3_src_i,
    output logic [7:0] p0_i_o,
    output logic [7:0] p1_i_o,
    output logic [7:0] p2_i_o,
    output logic [7:0] p3_i_o,
    output logic [7:0] wr_byte_o
);
    logic [7:0] p0_last = 8'h00; // last port0 wire level
    logic rd_strobe; // read strobe low on its pin
    logic wr_strobe; // write strobe low on its pin
    initial wr_byte_o = 8'h00;
    // strobes count only while the pin is driven low
    assign rd_strobe = p3_oe_i[7] & ~p3_o_i[7];
    assign wr_strobe = p3_oe_i[6] & ~p3_o_i[6];
    // memory drives port0 on read, else released wire wanders
    assign p0_i_o = rd_strobe ? RD_BYTE : ((p0_oe_i & p0_o_i) | (~p0_oe_i & ~p0_last));
    // ports 1/3: source where undriven, port2 pulled high
    assign p1_i_o = (p1_oe_i & p1_o_i) | (~p1_oe_i & p1_src_i);
    assign p2_i_o = (p2_oe_i & p2_o_i) | ~p2_oe_i;
    assign p3_i_o = (p3_oe_i & p3_o_i) | (~p3_oe_i & p3_src_i);
    // memory latches the port0 byte under the write strobe
    always @(posedge mclk_i) begin
        p0_last <= p0_i_o;
        if (wr_strobe) begin
            wr_byte_o <= p0_o_i;
        end
    end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "ppfm_defs.svh"
// ==========================================================
// pin mux bench
module tb;
    import ppfm_pkg::*;
    logic mclk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    ppfm_bus_t bus_phase_i;
    logic [15:0] bus_addr_i;
    logic [7:0] bus_wdata_i, bus_rdata_o, analog_sel_o, p1s, p3s, wr_byte;
    logic bus_wr_i, bus_rd_i, txd_i, sync_data_out_i, ccu_fault_input_i;
    logic [2:0] compare_out_i, capcom_out_i, capcom_in_o;
    logic timer2_count_input_o, timer2_trigger_input_o, rxd_o, ext_irq0_o, ext_irq1_pin_o;
    logic ext_irq2_pin_o, timer0_gate_o, timer1_gate_o, timer0_count_input_o;
    logic timer1_count_input_o;
    logic [7:0] p0_i, p0_o, p0_oe_o, p1_i, p1_o, p1_oe_o, p2_i, p2_o, p2_oe_o;
    logic [7:0] p3_i, p3_o, p3_oe_o;
    int fails = 0;
    int comparisons = 0;
    ppfm_top dut (.mclk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_phase_i, .bus_addr_i,
        .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .compare_out_i, .capcom_out_i,
        .txd_i, .sync_data_out_i, .timer2_count_input_o, .timer2_trigger_input_o,
        .capcom_in_o, .rxd_o, .ext_irq0_o, .ext_irq1_pin_o, .ext_irq2_pin_o,
        .timer0_gate_o, .timer1_gate_o, .timer0_count_input_o, .timer1_count_input_o,
        .analog_sel_o, .ccu_fault_input_i, .p0_i, .p0_o, .p0_oe_o, .p1_i, .p1_o,
        .p1_oe_o, .p2_i, .p2_o, .p2_oe_o, .p3_i, .p3_o, .p3_oe_o);
    ppfm_ext_model model (.mclk_i, .p0_o_i(p0_o), .p0_oe_i(p0_oe_o), .p1_o_i(p1_o),
        .p1_oe_i(p1_oe_o), .p2_o_i(p2_o), .p2_oe_i(p2_oe_o), .p3_o_i(p3_o),
        .p3_oe_i(p3_oe_o), .p1_src_i(p1s), .p3_src_i(p3s), .p0_i_o(p0_i),
        .p1_i_o(p1_i), .p2_i_o(p2_i), .p3_i_o(p3_i), .wr_byte_o(wr_byte));
    // ==========================================================
    // common tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // one classic cycle, held until ack is sampled high, then released
    task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            fails++;
            test_done();
        end
        tick(2);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk({p1_o, p2_o, p3_o}, 24'hFFFFFF);
        chk({p1_oe_o, p2_oe_o, p3_oe_o}, 24'h000000);
        wb(1'b0, `PPFM_ADR_P1_ANA, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, 4'hF, 32'h5A);
        wb(1'b0, 4'hF, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic t_port2();
        wb(1'b1, `PPFM_ADR_P2_LATCH, 32'h5A);
        chk({p2_o, p2_oe_o}, 16'h5AA5);
        tick(4);
        wb(1'b0, `PPFM_ADR_P2_PIN, 32'h0);
        chk(rdat, 32'h5A);
    endtask
    task automatic t_bus();
        bus_phase_i <= PPFM_BUS_FETCH;
        bus_addr_i <= 16'h1234;
        tick(2);
        chk({p2_o, p2_oe_o, p0_o, p0_oe_o}, 32'h12FF34FF);
        bus_phase_i <= PPFM_BUS_DATA8;
        bus_wdata_i <= 8'h9E;
        bus_wr_i <= 1'b1;
        tick(3);
        chk({p2_o, p2_oe_o, p0_o, p0_oe_o}, 32'h5AA59EFF);
        chk({p3_o[7:6], p3_oe_o[7:6], wr_byte}, 12'hB9E);
        bus_phase_i <= PPFM_BUS_DATA16;
        bus_addr_i <= 16'hBEEF;
        bus_wr_i <= 1'b0;
        bus_rd_i <= 1'b1;
        tick(6);
        chk({p2_o, p2_oe_o, p0_oe_o, bus_rdata_o}, 32'hBEFF00C3);
        chk({p3_o[7:6], p3_oe_o[7:6]}, 4'h7);
        bus_phase_i <= PPFM_BUS_IDLE;
        bus_rd_i <= 1'b0;
        tick(2);
        chk(p0_oe_o, 8'h00);
    endtask
    task automatic t_inputs();
        wb(1'b1, `PPFM_ADR_P1_ANA, 32'h1);
        wb(1'b1, `PPFM_ADR_P3_ANA, 32'h5);
        chk(analog_sel_o, 8'h51);
        p1s <= 8'hBA;
        p3s <= 8'hC3;
        tick(5);
        chk({timer2_count_input_o, timer2_trigger_input_o, capcom_in_o}, 5'h1A);
        chk({ext_irq0_o, timer0_gate_o, ext_irq1_pin_o, timer1_gate_o, timer0_count_input_o},
            5'h19);
        wb(1'b1, `PPFM_ADR_P1_ANA, 32'h0);
        wb(1'b1, `PPFM_ADR_P3_ANA, 32'h0);
        tick(5);
        chk({timer2_count_input_o, ext_irq0_o, timer0_count_input_o}, 3'h0);
        chk(timer1_count_input_o, 1'b0);
        p1s <= 8'hFF;
        p3s <= 8'hFF;
    endtask
    task automatic t_compare();
        compare_out_i <= 3'b101;
        capcom_out_i <= 3'b110;
        tick(2);
        chk({p1_o[7], p1_o[5], p1_o[3], p1_o[6], p1_o[4], p1_o[2]}, 6'h2E);
        wb(1'b1, `PPFM_ADR_P1_LATCH, 32'hF7);
        chk(p1_o[3], 1'b0);
        wb(1'b1, `PPFM_ADR_P1_LATCH, 32'hFF);
        wb(1'b1, `PPFM_ADR_TRAP_EN, 32'h3);
        wb(1'b1, `PPFM_ADR_TRAP_LVL, 32'h2);
        ccu_fault_input_i <= 1'b0;
        tick(5);
        chk({p1_o[7], p1_o[5], p1_o[3]}, 3'b110);
        wb(1'b0, `PPFM_ADR_STATUS, 32'h0);
        chk(rdat[0], 1'b0);
        ccu_fault_input_i <= 1'b1;
        tick(5);
        chk({p1_o[7], p1_o[5], p1_o[3]}, 3'b101);
    endtask
    task automatic t_serial();
        txd_i <= 1'b0;
        p3s <= 8'hBE;
        tick(5);
        chk({p3_o[1], rxd_o}, 2'b00);
        txd_i <= 1'b1;
        wb(1'b1, `PPFM_ADR_CTRL, 32'h1);
        sync_data_out_i <= 1'b0;
        tick(2);
        chk({p3_o[0], p3_oe_o[0]}, 2'b01);
        wb(1'b1, `PPFM_ADR_CTRL, 32'h2);
        tick(5);
        chk(ext_irq2_pin_o, 1'b0);
        wb(1'b1, `PPFM_ADR_CTRL, 32'h0);
        tick(5);
        chk(ext_irq2_pin_o, 1'b1);
    endtask
    // ==========================================================
    // clock, reset and main sequence
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        {reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, bus_wr_i, bus_rd_i} = 6'h0;
        {wb_adr_i, wb_dat_i, bus_addr_i, bus_wdata_i} = '0;
        wb_sel_i = 4'hF;
        bus_phase_i = PPFM_BUS_IDLE;
        {txd_i, sync_data_out_i, ccu_fault_input_i} = 3'b111;
        {compare_out_i, capcom_out_i} = 6'h3F;
        p1s = 8'hFF;
        p3s = 8'hFF;
        tick(10);
        reset_n_i <= 1'b1;
        tick(1);
        t_reset();
        t_port2();
        t_bus();
        t_inputs();
        t_compare();
        t_serial();
        test_done();
    end
endmodule
